// >>> rls_host_model.sv
// Purpose: host on the register port, serial or macro side
// Assumes: strobes launched just after a rising edge
// Notes: released address and data are inverted, never left at the last value
`timescale 1ns/1ps
module rls_host_model
    import rls_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rvalid,
    input wire logic [15:0] i_rdata,
    output logic [15:0] o_addr,
    output logic [15:0] o_wdata,
    output logic o_wr,
    output logic o_rd
);
    // idle port at time zero
    initial begin
        o_addr = 16'hffff;
        o_wdata = 16'hffff;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end
    // one-cycle write strobe
    task automatic wr(input logic [15:0] addr, input logic [15:0] data);
        logic [15:0] d;
        d = data;
        if (addr == ADDR_LAMP_CONTROL) begin
            d[15:14] = 2'b00;
        end
        @(posedge i_mclk);
        o_addr <= addr;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_mclk);
        o_wr <= 1'b0;
        o_addr <= ~addr;
        o_wdata <= ~d;
    endtask
    // read: answer is settled just after the edge that follows the strobe
    task automatic rd(input logic [15:0] addr, output logic [15:0] data, output logic ok);
        @(posedge i_mclk);
        o_addr <= addr;
        o_rd <= 1'b1;
        @(posedge i_mclk);
        o_rd <= 1'b0;
        o_addr <= ~addr;
        #1;
        ok = i_rvalid;
        data = i_rdata;
    endtask
endmodule

// >>> rls_pkg.sv
// Purpose: shared constants for the relay and lamp status register bank
// Assumes: 10 MHz system clock, 16-bit register port addressed by register number
// Notes: 32-bit registers take two consecutive register numbers
package rls_pkg;

    // register numbers (word addresses on the register port)
    localparam logic [15:0] ADDR_AMBIENT_LEGACY = 16'h0079;
    localparam logic [15:0] ADDR_ALARM_WORD = 16'h00ef;
    localparam logic [15:0] ADDR_SERIAL_NUMBER = 16'h021d;
    localparam logic [15:0] ADDR_CAL_DATE = 16'h021f;
    localparam logic [15:0] ADDR_AMBIENT_TEMP = 16'h04c9;
    localparam logic [15:0] ADDR_SP_STATE_FLAGS = 16'h1001;
    localparam logic [15:0] ADDR_RELAY_IMAGE = 16'h1003;
    localparam logic [15:0] ADDR_DEENERGIZE_MASK = 16'h1005;
    localparam logic [15:0] ADDR_FW_VERSION = 16'h100a;
    localparam logic [15:0] ADDR_DIGITAL_INPUTS = 16'h100c;
    localparam logic [15:0] ADDR_MACRO_STATE = 16'h100d;
    localparam logic [15:0] ADDR_LAMP_CONTROL = 16'h100e;
    localparam logic [15:0] ADDR_VIEW_BLANKING = 16'h1154;
    localparam logic [15:0] ADDR_NVM_SIZE = 16'h1155;
    localparam logic [15:0] ADDR_VIEW_POINTER = 16'h201c;
    localparam logic [15:0] ADDR_PREV_BOOT_ERROR = 16'h20ef;
    localparam logic [15:0] ADDR_BOOT_ERROR = 16'h20f3;
    localparam logic [15:0] ADDR_BOOT_LIMIT = 16'h20f4;
    localparam logic [15:0] ADDR_PRODUCT_TEXT = 16'h40b5;
    localparam logic [2:0] PRODUCT_TEXT_WORDS = 3'h7;

    // lamp control register layout
    localparam int LAMP_STATE_LSB = 0;
    localparam int LAMP_OVERRIDE_LSB = 8;
    localparam int LAMP_COUNT = 6;
    localparam int LAMP_BACKLIGHT_BIT = 0;
    localparam int LAMP_BUZZER_BIT = 1;
    localparam int SP_BUZZER_IDX = 4;
    localparam int SP_BACKLIGHT_IDX = 5;
    localparam int RELAY_FAST_COUNT = 6;

    // reset values
    localparam logic [5:0] LAMP_STATE_RESET = 6'h01;
    localparam logic [5:0] LAMP_OVERRIDE_RESET = 6'h03;
    localparam logic [7:0] BOOT_LIMIT_RESET = 8'h00;

    // control output period
    localparam int CLK_PERIOD_NS = 100;
    localparam int CTRL_FAST_NS = 10_000_000;
    localparam int CTRL_SLOW_NS = 100_000_000;
    localparam int CTRL_FAST_CYCLES = CTRL_FAST_NS / CLK_PERIOD_NS;
    localparam int CTRL_SLOW_CYCLES = CTRL_SLOW_NS / CLK_PERIOD_NS;

endpackage

// >>> rls_regs.sv
// Purpose: relay image, panel lamp and status register bank
// Assumes: register port and setpoint logic run on i_mclk; option and digital pins are asynchronous
// Notes: 32-bit values take two register numbers, low word first except the legacy temperature
// Functional notes
// - relay image: 16 bits, bit n is relay n+1, one means energized
// - setpoint activation is kept apart from relay state
// - each control period the setpoint result overwrites the relay image
// - relays whose setpoint source is off keep the host-written bit
// - relays 1-6 follow writes at once, others at the control rate, or at once in direct mode
// - lamp register reads always give the true lamp states
// - bits 0-5 hold lamps 6 down to 1, one means on
// - bits 8-13 pick remote (1) or controller (0) drive, lamps 6 to 1
// - a lamp in remote mode is driven from its written state bit
// - two-line display: lamps 1-4 only, lamp 5/6 controls become buzzer/backlight
// - two-line display: bit 0 is the backlight, on by default
// - two-line display: bit 1 is the buzzer, one means sounding
// - read-only setpoint status register shows every setpoint state
// - 32-bit alarm word reports setpoint states and accepts control writes
// - boot error at or below limit halts; above limit loads defaults
// - current boot error in 8 bits, zero is clean; last error kept separately
// - macro state number clears on return to the operational display
// - calibration date: year high word, month high byte, day low byte
// - read-only register gives fitted non-volatile memory in kilobytes
// - legacy temperature float reads most significant word first
`timescale 1ns/1ps
module rls_regs
    import rls_pkg::*;
#(
    parameter int FAST_CYCLES = CTRL_FAST_CYCLES,
    parameter int SLOW_CYCLES = CTRL_SLOW_CYCLES,
    parameter logic [111:0] PRODUCT_TEXT = 112'h44_45_56_49_43_45_20_20_20_20_20_20_20_20 // arbitrary
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic [15:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [15:0] i_reg_wdata,
    input wire logic i_reg_rd,
    output logic [15:0] o_reg_rdata,
    output logic o_reg_rvalid,
    input wire logic [15:0] i_sp_active,
    input wire logic [15:0] i_sp_source_off,
    input wire logic [15:0] i_relay_calc,
    input wire logic i_fast_rate,
    input wire logic i_direct_mode,
    output logic o_ctrl_tick,
    output logic [15:0] o_relay,
    output logic [15:0] o_sp_force,
    output logic [15:0] o_sp_remote,
    output logic [15:0] o_deenergize_mask,
    input wire logic [5:0] i_lamp_ctrl,
    input wire logic i_two_line_pin,
    input wire logic [15:0] i_digital_pins,
    output logic [5:0] o_lamp,
    output logic o_buzzer,
    output logic o_backlight,
    input wire logic i_boot_done,
    input wire logic [7:0] i_boot_code,
    output logic o_halt,
    output logic o_load_defaults,
    input wire logic i_oper_display,
    output logic [15:0] o_macro_state,
    input wire logic [31:0] i_ambient_temp,
    input wire logic [31:0] i_serial_number,
    input wire logic [15:0] i_fw_version,
    input wire logic [15:0] i_nvm_kbytes,
    output logic [31:0] o_cal_date,
    output logic [15:0] o_view_blanking,
    output logic [7:0] o_view_pointer
);
    // stored state
    logic [15:0] relay_image;
    logic [15:0] relay_pins_slow;
    logic [5:0] lamp_state;
    logic [5:0] lamp_override;
    logic [7:0] boot_error;
    logic [7:0] prev_boot_error;
    logic [7:0] boot_limit;
    logic [19:0] tick_count;

    // synchronised pins
    logic two_line;
    logic [15:0] digital_sync;

    // decode and datapath wires
    logic wr_alarm_lo;
    logic wr_alarm_hi;
    logic wr_relay;
    logic wr_lamp;
    logic wr_macro;
    logic tick_now;
    logic [19:0] tick_limit;
    logic [15:0] relay_keep;
    logic [15:0] next_relay_image;
    logic [5:0] lamp_ctrl_eff;
    logic [5:0] lamp_actual;
    logic [15:0] lamp_word;
    logic [15:0] text_off;
    logic [2:0] text_idx;
    logic text_hit;
    logic [15:0] text_word;
    logic [15:0] next_rdata;

    rls_sync #(.WIDTH(1)) u_opt_sync (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_pin(i_two_line_pin),
        .o_level(two_line)
    );

    rls_sync #(.WIDTH(16)) u_din_sync (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_pin(i_digital_pins),
        .o_level(digital_sync)
    );

    // write strobes; read-only numbers have no strobe at all
    assign wr_alarm_lo = i_reg_wr && (i_reg_addr == ADDR_ALARM_WORD);
    assign wr_alarm_hi = i_reg_wr && (i_reg_addr == ADDR_ALARM_WORD + 16'h0001);
    assign wr_relay = i_reg_wr && (i_reg_addr == ADDR_RELAY_IMAGE);
    assign wr_lamp = i_reg_wr && (i_reg_addr == ADDR_LAMP_CONTROL);
    assign wr_macro = i_reg_wr && (i_reg_addr == ADDR_MACRO_STATE);

    // control output period counter, rate picked by the setpoint configuration
    assign tick_limit = i_fast_rate ? 20'(FAST_CYCLES - 1) : 20'(SLOW_CYCLES - 1);
    assign tick_now = (tick_count >= tick_limit);
    assign o_ctrl_tick = tick_now;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            tick_count <= 20'h00000;
        end else begin
            tick_count <= tick_now ? 20'h00000 : tick_count + 20'h00001;
        end
    end

    // relay image: setpoint result wins on its tick, host writes otherwise
    // a host write in the tick cycle is lost for setpoint-driven relays on purpose
    assign relay_keep = wr_relay ? i_reg_wdata : relay_image;
    assign next_relay_image = tick_now ?
        ((i_relay_calc & ~i_sp_source_off) | (relay_keep & i_sp_source_off)) :
        relay_keep;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            relay_image <= 16'h0000;
        end else begin
            relay_image <= next_relay_image;
        end
    end

    // slow relays copy the image at the control rate, or every cycle in direct mode
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            relay_pins_slow <= 16'h0000;
        end else if (tick_now || i_direct_mode) begin
            relay_pins_slow <= next_relay_image;
        end
    end

    // relays 1-6 are wired straight from the image flops
    assign o_relay = {relay_pins_slow[15:RELAY_FAST_COUNT], relay_image[RELAY_FAST_COUNT-1:0]};

    // alarm word: low half drives setpoints, high half selects remote mode
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_sp_force <= 16'h0000;
            o_sp_remote <= 16'h0000;
        end else begin
            if (wr_alarm_lo) begin
                o_sp_force <= i_reg_wdata;
            end
            if (wr_alarm_hi) begin
                o_sp_remote <= i_reg_wdata;
            end
        end
    end

    // in two-line mode the buzzer and backlight follow setpoints 5 and 6 when not remote
    assign lamp_ctrl_eff = two_line ?
        {i_lamp_ctrl[5:2], i_sp_active[SP_BUZZER_IDX], i_sp_active[SP_BACKLIGHT_IDX]} : i_lamp_ctrl;
    assign lamp_actual = (lamp_override & lamp_state) | (~lamp_override & lamp_ctrl_eff);
    // bits 6,7 and 14,15 always read zero, whatever was written
    assign lamp_word = {2'b00, lamp_override, 2'b00, lamp_actual};

    // lamp state and mode bits; reserved and don't-care bits are not stored
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            lamp_state <= LAMP_STATE_RESET;
            lamp_override <= LAMP_OVERRIDE_RESET;
        end else if (wr_lamp) begin
            lamp_state <= i_reg_wdata[LAMP_STATE_LSB +: LAMP_COUNT];
            lamp_override <= i_reg_wdata[LAMP_OVERRIDE_LSB +: LAMP_COUNT];
        end
    end

    // lamp pins: bit 0 is lamp 6, bit 5 is lamp 1
    assign o_lamp = two_line ? {lamp_actual[5:2], 2'b00} : lamp_actual;
    assign o_backlight = two_line & lamp_actual[LAMP_BACKLIGHT_BIT];
    assign o_buzzer = two_line & lamp_actual[LAMP_BUZZER_BIT];

    // boot error capture and limit check
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            boot_error <= 8'h00;
            prev_boot_error <= 8'h00;
            boot_limit <= BOOT_LIMIT_RESET;
            o_halt <= 1'b0;
            o_load_defaults <= 1'b0;
        end else begin
            o_load_defaults <= 1'b0;
            if (i_boot_done) begin
                boot_error <= i_boot_code;
                if (i_boot_code != 8'h00) begin
                    prev_boot_error <= i_boot_code;
                    o_halt <= (i_boot_code <= boot_limit);
                    o_load_defaults <= (i_boot_code > boot_limit);
                end else begin
                    o_halt <= 1'b0;
                end
            end else if (i_reg_wr) begin
                if (i_reg_addr == ADDR_BOOT_ERROR) begin
                    boot_error <= i_reg_wdata[7:0];
                end
                if (i_reg_addr == ADDR_PREV_BOOT_ERROR) begin
                    prev_boot_error <= i_reg_wdata[7:0];
                end
                if (i_reg_addr == ADDR_BOOT_LIMIT) begin
                    boot_limit <= i_reg_wdata[7:0];
                end
            end
        end
    end

    // macro state, calibration date and view settings
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_macro_state <= 16'h0000;
            o_cal_date <= 32'h00000000;
            o_view_blanking <= 16'h0000;
            o_view_pointer <= 8'h00;
        end else begin
            if (i_oper_display) begin
                o_macro_state <= 16'h0000;
            end else if (wr_macro) begin
                o_macro_state <= i_reg_wdata;
            end
            if (i_reg_wr && i_reg_addr == ADDR_CAL_DATE) begin
                o_cal_date[15:0] <= i_reg_wdata;
            end
            if (i_reg_wr && i_reg_addr == ADDR_CAL_DATE + 16'h0001) begin
                o_cal_date[31:16] <= i_reg_wdata;
            end
            if (i_reg_wr && i_reg_addr == ADDR_VIEW_BLANKING) begin
                o_view_blanking <= i_reg_wdata;
            end
            if (i_reg_wr && i_reg_addr == ADDR_VIEW_POINTER) begin
                o_view_pointer <= i_reg_wdata[7:0];
            end
        end
    end

    // text register words, first characters in the first word
    assign text_off = i_reg_addr - ADDR_PRODUCT_TEXT;
    assign text_hit = (i_reg_addr >= ADDR_PRODUCT_TEXT) && (text_off < {13'h0000, PRODUCT_TEXT_WORDS});
    assign text_idx = text_off[2:0];
    assign text_word = PRODUCT_TEXT[111 - 16 * text_idx -: 16];

    // read selection; unmapped numbers read zero
    always_comb begin
        next_rdata = 16'h0000;
        if (text_hit) begin
            next_rdata = text_word;
        end else begin
            case (i_reg_addr)
                ADDR_AMBIENT_LEGACY: next_rdata = i_ambient_temp[31:16];
                ADDR_AMBIENT_LEGACY + 16'h0001: next_rdata = i_ambient_temp[15:0];
                ADDR_ALARM_WORD: next_rdata = i_sp_active;
                ADDR_ALARM_WORD + 16'h0001: next_rdata = o_sp_remote;
                ADDR_SERIAL_NUMBER: next_rdata = i_serial_number[15:0];
                ADDR_SERIAL_NUMBER + 16'h0001: next_rdata = i_serial_number[31:16];
                ADDR_CAL_DATE: next_rdata = o_cal_date[15:0];
                ADDR_CAL_DATE + 16'h0001: next_rdata = o_cal_date[31:16];
                ADDR_AMBIENT_TEMP: next_rdata = i_ambient_temp[15:0];
                ADDR_AMBIENT_TEMP + 16'h0001: next_rdata = i_ambient_temp[31:16];
                ADDR_SP_STATE_FLAGS: next_rdata = i_sp_active;
                ADDR_RELAY_IMAGE: next_rdata = relay_image;
                ADDR_DEENERGIZE_MASK: next_rdata = o_deenergize_mask;
                ADDR_FW_VERSION: next_rdata = i_fw_version;
                ADDR_DIGITAL_INPUTS: next_rdata = digital_sync;
                ADDR_MACRO_STATE: next_rdata = o_macro_state;
                ADDR_LAMP_CONTROL: next_rdata = lamp_word;
                ADDR_VIEW_BLANKING: next_rdata = o_view_blanking;
                ADDR_NVM_SIZE: next_rdata = i_nvm_kbytes;
                ADDR_VIEW_POINTER: next_rdata = {8'h00, o_view_pointer};
                ADDR_PREV_BOOT_ERROR: next_rdata = {8'h00, prev_boot_error};
                ADDR_BOOT_ERROR: next_rdata = {8'h00, boot_error};
                ADDR_BOOT_LIMIT: next_rdata = {8'h00, boot_limit};
                default: next_rdata = 16'h0000;
            endcase
        end
    end

    // read data and de-energize mask registers
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_reg_rdata <= 16'h0000;
            o_reg_rvalid <= 1'b0;
            o_deenergize_mask <= 16'h0000;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                o_reg_rdata <= next_rdata;
            end
            if (i_reg_wr && i_reg_addr == ADDR_DEENERGIZE_MASK) begin
                o_deenergize_mask <= i_reg_wdata;
            end
        end
    end
endmodule

// >>> rls_regs_properties.sv
// Purpose: port-level checks for the relay and lamp register bank
// Assumes: one clock domain, async active-high reset
// Notes: bound to every rls_regs instance at the foot of this file
`timescale 1ns/1ps
module rls_regs_props
    import rls_pkg::*;
#(
    parameter int FAST_CYCLES = 8
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic [15:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [15:0] i_reg_wdata,
    input wire logic i_reg_rd,
    input wire logic o_reg_rvalid,
    input wire logic [15:0] i_sp_source_off,
    input wire logic [15:0] i_relay_calc,
    input wire logic i_direct_mode,
    input wire logic o_ctrl_tick,
    input wire logic [15:0] o_relay,
    input wire logic [5:0] i_lamp_ctrl,
    input wire logic i_two_line_pin,
    input wire logic [5:0] o_lamp,
    input wire logic i_boot_done,
    input wire logic [7:0] i_boot_code,
    input wire logic o_halt,
    input wire logic o_load_defaults,
    input wire logic i_oper_display,
    input wire logic [15:0] o_macro_state
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    // decoded writes, and last cycle's write data for the fast relay and lamp checks
    wire logic relay_wr = i_reg_wr && (i_reg_addr == ADDR_RELAY_IMAGE);
    wire logic lamp_wr = i_reg_wr && (i_reg_addr == ADDR_LAMP_CONTROL);
    logic [15:0] wd_q;
    always_ff @(posedge i_mclk) begin
        wd_q <= i_reg_wdata;
    end
    property p_rvalid; i_reg_rd |=> o_reg_rvalid; endproperty
    a_rvalid: assert property (p_rvalid) else $error("read not answered next cycle");
    property p_relay_fast; relay_wr && !o_ctrl_tick |=> o_relay[5:0] == wd_q[5:0]; endproperty
    a_relay_fast: assert property (p_relay_fast) else $error("relays 1-6 missed write");
    // both cycles out of direct mode, so a mode switch never looks like a pin change
    property p_relay_slow;
        !o_ctrl_tick && !i_direct_mode ##1 !i_direct_mode |-> $stable(o_relay[15:6]);
    endproperty
    a_relay_slow: assert property (p_relay_slow) else $error("slow relays moved off tick");
    property p_tick_load; o_ctrl_tick && i_sp_source_off == 16'h0 |=> o_relay == $past(i_relay_calc); endproperty
    a_tick_load: assert property (p_tick_load) else $error("tick did not load result");
    property p_keep_off;
        o_ctrl_tick && !relay_wr |=> ((o_relay ^ $past(o_relay)) & $past(i_sp_source_off) & 16'h003f) == 16'h0;
    endproperty
    a_keep_off: assert property (p_keep_off) else $error("source-off relay changed");
    property p_tick_gap; o_ctrl_tick && (FAST_CYCLES > 7) |=> !o_ctrl_tick [*7]; endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("control ticks too close");
    property p_lamp;
        lamp_wr && !i_two_line_pin |=> o_lamp == ((wd_q[13:8] & wd_q[5:0]) | (~wd_q[13:8] & i_lamp_ctrl));
    endproperty
    a_lamp: assert property (p_lamp) else $error("lamp drive wrong after write");
    property p_halt_clr; i_boot_done && i_boot_code == 8'h00 |=> !o_halt; endproperty
    a_halt_clr: assert property (p_halt_clr) else $error("clean boot left halt");
    property p_defaults; o_load_defaults |-> $past(i_boot_done) || $past(i_boot_done, 2); endproperty
    a_defaults: assert property (p_defaults) else $error("defaults without boot event");
    property p_macro; i_oper_display |=> o_macro_state == 16'h0000; endproperty
    a_macro: assert property (p_macro) else $error("macro state not cleared");
endmodule

bind rls_regs rls_regs_props #(.FAST_CYCLES(FAST_CYCLES)) i_rls_regs_props (.*);

// >>> rls_regs_test.sv
// Purpose: directed register and pin tests of the relay and lamp bank
// Assumes: short control period of 8 cycles
// Notes: ambient temperature and memory size are tied
`timescale 1ns/1ps
module rls_regs_test;
    import rls_pkg::*;
    logic i_mclk, i_rst, i_fast_rate, i_direct_mode, i_two_line_pin, i_boot_done, i_oper_display, ok, seen;
    logic [15:0] i_sp_active, i_sp_source_off, i_relay_calc, rv;
    logic [5:0] i_lamp_ctrl;
    logic [7:0] i_boot_code;
    wire logic [15:0] addr, wdata, rdata, relay, force_w, remote_w, macro;
    wire logic wr, rd, rvalid, tick, halt, dflt, buzzer, backlight;
    wire logic [5:0] lamp;
    wire logic [31:0] cal;
    int bad_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    rls_regs #(.FAST_CYCLES(8), .SLOW_CYCLES(20)) i_rls_regs (.i_mclk(i_mclk), .i_rst(i_rst),
        .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata), .i_reg_rd(rd), .o_reg_rdata(rdata),
        .o_reg_rvalid(rvalid), .i_sp_active(i_sp_active), .i_sp_source_off(i_sp_source_off),
        .i_relay_calc(i_relay_calc), .i_fast_rate(i_fast_rate), .i_direct_mode(i_direct_mode),
        .o_ctrl_tick(tick), .o_relay(relay), .o_sp_force(force_w), .o_sp_remote(remote_w),
        .o_deenergize_mask(), .i_lamp_ctrl(i_lamp_ctrl), .i_two_line_pin(i_two_line_pin),
        .i_digital_pins(i_relay_calc), .o_lamp(lamp), .o_buzzer(buzzer), .o_backlight(backlight),
        .i_boot_done(i_boot_done), .i_boot_code(i_boot_code), .o_halt(halt), .o_load_defaults(dflt),
        .i_oper_display(i_oper_display), .o_macro_state(macro), .i_ambient_temp(32'h41480a0b),
        .i_serial_number({i_relay_calc, i_sp_active}), .i_fw_version(i_sp_active), .i_nvm_kbytes(16'h0040),
        .o_cal_date(cal), .o_view_blanking(), .o_view_pointer());
    rls_host_model i_rls_host_model (.i_mclk(i_mclk), .i_rvalid(rvalid), .i_rdata(rdata), .o_addr(addr),
        .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
    // free-running clock
    initial begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end
    // hang guard, well above the expected run length
    always @(posedge i_mclk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            bad_count++;
            summarize();
        end
    end
    task automatic summarize();
        $display("compares %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen_v, input logic [31:0] exp_v);
        samples_checked++;
        if (seen_v !== exp_v) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp_v, seen_v);
        end
    endtask
    // read and compare, answer strobe included
    task automatic rdc(input string name, input logic [15:0] a, input logic [15:0] exp_v);
        i_rls_host_model.rd(a, rv, ok);
        check(name, {ok, rv}, {1'b1, exp_v});
    endtask
    // returns just after the edge that raised the tick
    task automatic wait_tick();
        for (int n = 0; n < 30 && tick !== 1'b1; n++) begin
            @(posedge i_mclk);
            #1;
        end
    endtask
    // boot event; any defaults pulse within three cycles is caught
    task automatic boot(input logic [7:0] code);
        @(posedge i_mclk);
        i_boot_done <= 1'b1;
        i_boot_code <= code;
        @(posedge i_mclk);
        i_boot_done <= 1'b0;
        seen = 1'b0;
        for (int n = 0; n < 3; n++) begin
            #1;
            seen = seen | dflt;
            @(posedge i_mclk);
        end
    endtask
    // main sequence
    initial begin
        i_rst = 1'b1;
        {i_fast_rate, i_direct_mode, i_two_line_pin, i_boot_done, i_oper_display} = 5'b10000;
        i_sp_active = 16'h1234;
        i_sp_source_off = 16'h0000;
        i_relay_calc = 16'h0f0f;
        i_lamp_ctrl = 6'h2a;
        i_boot_code = 8'h00;
        repeat (6) @(posedge i_mclk);
        i_rst <= 1'b0;
        rdc("lamp reset", ADDR_LAMP_CONTROL, 16'h0329);
        i_rls_host_model.wr(ADDR_LAMP_CONTROL, 16'hffd5);
        rdc("lamp remote", ADDR_LAMP_CONTROL, 16'h3f15);
        i_rls_host_model.wr(ADDR_LAMP_CONTROL, 16'h0c0c);
        rdc("lamp mixed", ADDR_LAMP_CONTROL, 16'h0c2e);
        @(posedge i_mclk);
        i_sp_source_off <= 16'h00ff;
        wait_tick();
        i_rls_host_model.wr(ADDR_RELAY_IMAGE, 16'ha5c3);
        #1;
        check("relay fast", relay, 16'h0f03);
        wait_tick();
        @(posedge i_mclk);
        #1;
        check("relay tick", relay, 16'h0fc3);
        rdc("relay image", ADDR_RELAY_IMAGE, 16'h0fc3);
        i_direct_mode <= 1'b1;
        wait_tick();
        i_rls_host_model.wr(ADDR_RELAY_IMAGE, 16'h5a00);
        #1;
        check("relay direct", relay, 16'h5a00);
        i_direct_mode <= 1'b0;
        rdc("alarm", ADDR_ALARM_WORD, 16'h1234);
        rdc("sp flags", ADDR_SP_STATE_FLAGS, 16'h1234);
        i_rls_host_model.wr(ADDR_SP_STATE_FLAGS, 16'hffff);
        rdc("sp flags ro", ADDR_SP_STATE_FLAGS, 16'h1234);
        i_rls_host_model.wr(ADDR_ALARM_WORD, 16'h5555);
        i_rls_host_model.wr(ADDR_ALARM_WORD + 16'h0001, 16'h00aa);
        #1;
        check("alarm ctrl", {remote_w, force_w}, 32'h00aa5555);
        i_rls_host_model.wr(ADDR_BOOT_LIMIT, 16'h0010);
        boot(8'h10);
        check("boot at limit", {halt, seen}, 2'b10);
        rdc("boot state", ADDR_BOOT_ERROR, 16'h0010);
        boot(8'h20);
        check("boot above", seen, 1'b1);
        rdc("prev boot", ADDR_PREV_BOOT_ERROR, 16'h0020);
        boot(8'h00);
        check("boot clean", {halt, seen}, 2'b00);
        rdc("boot clear", ADDR_BOOT_ERROR, 16'h0000);
        i_rls_host_model.wr(ADDR_MACRO_STATE, 16'h1234);
        #1;
        check("macro", macro, 16'h1234);
        i_oper_display <= 1'b1;
        @(posedge i_mclk);
        i_oper_display <= 1'b0;
        @(posedge i_mclk);
        #1;
        check("macro clear", macro, 16'h0000);
        i_rls_host_model.wr(ADDR_CAL_DATE, 16'h0c1f);
        i_rls_host_model.wr(ADDR_CAL_DATE + 16'h0001, 16'h07e8);
        #1;
        check("cal date", cal, 32'h07e80c1f);
        rdc("nvm", ADDR_NVM_SIZE, 16'h0040);
        i_rls_host_model.wr(ADDR_NVM_SIZE, 16'hffff);
        rdc("nvm ro", ADDR_NVM_SIZE, 16'h0040);
        rdc("temp msw", ADDR_AMBIENT_LEGACY, 16'h4148);
        rdc("temp lsw", ADDR_AMBIENT_LEGACY + 16'h0001, 16'h0a0b);
        rdc("unmapped", 16'h3000, 16'h0000);
        rdc("din", ADDR_DIGITAL_INPUTS, 16'h0f0f);
        i_two_line_pin <= 1'b1;
        repeat (5) @(posedge i_mclk);
        i_rls_host_model.wr(ADDR_LAMP_CONTROL, 16'h0302);
        #1;
        check("two-line", {backlight, buzzer, lamp[1:0]}, 4'b0100);
        rdc("two-line read", ADDR_LAMP_CONTROL, 16'h032a);
        i_sp_active <= 16'h1224;
        i_rls_host_model.wr(ADDR_LAMP_CONTROL, 16'h0000);
        #1;
        check("two-line ctrl", {backlight, buzzer}, 2'b10);
        i_fast_rate <= 1'b0;
        repeat (60) @(posedge i_mclk);
        summarize();
    end
endmodule

// >>> rls_sync.sv
// Purpose: three-stage synchroniser with agreement filter for pin inputs
// Assumes: input may change at any time relative to i_mclk
// Notes: output moves only when stages two and three agree
`timescale 1ns/1ps
module rls_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_pin,
    output logic [WIDTH-1:0] o_level
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] agree;

    // stage1 is only ever read by stage2
    assign agree = ~(stage2 ^ stage3);

    // shift chain, then accept bits where the last two stages match
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            o_level <= '0;
        end else begin
            stage1 <= i_pin;
            stage2 <= stage1;
            stage3 <= stage2;
            o_level <= (agree & stage3) | (~agree & o_level);
        end
    end
endmodule
